// [rtl/lecc_pkg.sv]
/*
 * Constants for the lane error counter control block: register offsets,
 * field positions, reset values and counter limits.
 * Assumes a configuration port back end with a 12-bit register address.
 */
package lecc_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int CNT_W = 8;
    localparam int FIELD_W = 3;
    localparam int NUM_CNT = 9;

    localparam logic [11:0] LANE6_CTRL_OFFSET = 12'h486;
    localparam logic [11:0] LANE7_CTRL_OFFSET = 12'h487;
    localparam logic [11:0] LANE0_SAT_OFFSET = 12'h488;

    localparam int ENABLE_LSB = 3;
    localparam int CLEAR_LSB = 0;
    localparam int SAT_LSB = 0;

    localparam int BIT_UNEXPECTED = 2;
    localparam int BIT_INVALID = 1;
    localparam int BIT_DISPARITY = 0;

    localparam logic [2:0] ENABLE_RESET = 3'h7;
    localparam logic [2:0] CLEAR_RESET = 3'h7;
    localparam logic [2:0] SAT_RESET = 3'h7;

    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [7:0] COUNT_STEP = 8'h01;
endpackage : lecc_pkg

// [rtl/lecc_err_counter.sv]
/*
 * One eight-bit error event counter with enable, level clear and
 * optional hold at terminal count.
 * Assumes error strobes and controls are on the counter's own clock.
 */
module lecc_err_counter
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    input wire logic clear_i,
    input wire logic saturate_i,
    input wire logic error_i,
    output logic [7:0] count_o
);
    logic [7:0] count_reg;
    logic [7:0] count_next;
    wire at_max = (count_reg == lecc_pkg::COUNT_MAX);
    wire hold = saturate_i && at_max;
    wire bump = enable_i && error_i && !hold;

    // Clear wins so software always sees zero after a clear
    assign count_next = clear_i ? lecc_pkg::COUNT_ZERO :
                        bump ? 8'(count_reg + lecc_pkg::COUNT_STEP) :
                        count_reg;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count_reg <= lecc_pkg::COUNT_ZERO;
        end
        else
        begin
            count_reg <= count_next;
        end
    end

    assign count_o = count_reg;
endmodule : lecc_err_counter

// [rtl/lecc_top.sv]
/*
 * Lane error counter control: control registers for lanes 6, 7 and the
 * lane-0 terminal hold, and nine error counters (lanes 0, 6 and 7).
 * Assumes the configuration serial port back end presents single-cycle
 * register writes and reads on sys_clk_i, and that error strobes come
 * from receiver logic on the same clock.
 */
// Operation
// - Lane 6/7 enables at [5:3], reset all on
// - Field bits: 2 unexpected, 1 invalid, 0 disparity
// - Lane 7 clear bits zero matching counters
// - Lane 0 hold bit: stop at 0xFF
// - Hold bit clear: counter wraps to zero
module lecc_top
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [2:0] lane0_counter_enables_i,
    input wire logic [2:0] lane0_counter_clears_i,
    input wire logic [2:0] lane0_errors_i,
    input wire logic [2:0] lane6_errors_i,
    input wire logic [2:0] lane7_errors_i,
    output logic [23:0] lane0_counts_o,
    output logic [23:0] lane6_counts_o,
    output logic [23:0] lane7_counts_o
);
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    logic [2:0] lane6_counter_enables_reg;
    logic [2:0] lane6_counter_clears_reg;
    logic [2:0] lane7_counter_enables_reg;
    logic [2:0] lane7_counter_clears_reg;
    logic [2:0] lane0_counter_saturate_enable_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    wire sel_lane6 = (reg_addr_i == lecc_pkg::LANE6_CTRL_OFFSET);
    wire sel_lane7 = (reg_addr_i == lecc_pkg::LANE7_CTRL_OFFSET);
    wire sel_sat0 = (reg_addr_i == lecc_pkg::LANE0_SAT_OFFSET);
    wire wr_lane6 = reg_wr_i && sel_lane6;
    wire wr_lane7 = reg_wr_i && sel_lane7;
    wire wr_sat0 = reg_wr_i && sel_sat0;
    wire [2:0] wr_enables = reg_wdata_i[lecc_pkg::ENABLE_LSB +: lecc_pkg::FIELD_W];
    wire [2:0] wr_clears = reg_wdata_i[lecc_pkg::CLEAR_LSB +: lecc_pkg::FIELD_W];
    wire [2:0] wr_sat = reg_wdata_i[lecc_pkg::SAT_LSB +: lecc_pkg::FIELD_W];

    // Reserved bits read as zero
    wire [7:0] rd_lane6 = {2'h0, lane6_counter_enables_reg, lane6_counter_clears_reg};
    wire [7:0] rd_lane7 = {2'h0, lane7_counter_enables_reg, lane7_counter_clears_reg};
    wire [7:0] rd_sat0 = {5'h00, lane0_counter_saturate_enable_reg};
    assign rdata_next = !reg_rd_i ? rdata_reg :
                        sel_lane6 ? rd_lane6 :
                        sel_lane7 ? rd_lane7 :
                        sel_sat0 ? rd_sat0 :
                        8'h00;

    always_ff @(posedge sys_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            lane6_counter_enables_reg <= lecc_pkg::ENABLE_RESET;
            lane7_counter_enables_reg <= lecc_pkg::ENABLE_RESET;
            lane6_counter_clears_reg <= lecc_pkg::CLEAR_RESET;
            lane7_counter_clears_reg <= lecc_pkg::CLEAR_RESET;
            lane0_counter_saturate_enable_reg <= lecc_pkg::SAT_RESET;
            rdata_reg <= 8'h00;
        end
        else
        begin
            if (wr_lane6)
            begin
                lane6_counter_enables_reg <= wr_enables;
                lane6_counter_clears_reg <= wr_clears;
            end
            if (wr_lane7)
            begin
                lane7_counter_enables_reg <= wr_enables;
                lane7_counter_clears_reg <= wr_clears;
            end
            if (wr_sat0)
            begin
                lane0_counter_saturate_enable_reg <= wr_sat;
            end
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // Index k: lane group k/3 (0, 6, 7), field bit k%3
    wire [8:0] cnt_enable = {lane7_counter_enables_reg, lane6_counter_enables_reg, lane0_counter_enables_i};
    wire [8:0] cnt_clear = {lane7_counter_clears_reg, lane6_counter_clears_reg, lane0_counter_clears_i};
    // Hold field is used live; safe only because it is changed in soft reset
    wire [8:0] cnt_sat = {6'h00, lane0_counter_saturate_enable_reg};
    wire [8:0] cnt_error = {lane7_errors_i, lane6_errors_i, lane0_errors_i};
    wire [71:0] cnt_value;

    genvar k;
    generate
        for (k = 0; k < lecc_pkg::NUM_CNT; k++)
        begin : g_cnt
            lecc_err_counter u_cnt
            (
                .clk_i(sys_clk_i),
                .rst_n_i(rst_n_reg),
                .enable_i(cnt_enable[k]),
                .clear_i(cnt_clear[k]),
                .saturate_i(cnt_sat[k]),
                .error_i(cnt_error[k]),
                .count_o(cnt_value[k*8 +: 8])
            );
        end
    endgenerate

    // Output packing puts bit 2 (unexpected) in the top byte
    assign lane0_counts_o = {cnt_value[16 +: 8], cnt_value[8 +: 8], cnt_value[0 +: 8]};
    assign lane6_counts_o = {cnt_value[40 +: 8], cnt_value[32 +: 8], cnt_value[24 +: 8]};
    assign lane7_counts_o = {cnt_value[64 +: 8], cnt_value[56 +: 8], cnt_value[48 +: 8]};

    wire [7:0] l7_unexp = lane7_counts_o[23:16];
    wire [7:0] l7_disp = lane7_counts_o[7:0];
    wire [7:0] l7_inval = lane7_counts_o[15:8];
    wire [7:0] l0_unexp = lane0_counts_o[23:16];
    wire [7:0] l6_disp = lane6_counts_o[7:0];

    property p_enable_write;
        @(posedge sys_clk_i) disable iff (!rst_n_reg)
        wr_lane6 |=> (lane6_counter_enables_reg == $past(reg_wdata_i[5:3]));
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("lane6 enable field not written");

    property p_reset_enables;
        @(posedge sys_clk_i)
        $rose(rst_n_reg) |-> (lane6_counter_enables_reg == 3'h7) && (lane7_counter_enables_reg == 3'h7);
    endproperty
    a_reset_enables: assert property (p_reset_enables) else $error("enables not all set after reset");

    sequence s_l7_unexp_event;
        lane7_counter_enables_reg[2] && !lane7_counter_clears_reg[2] && lane7_errors_i[2];
    endsequence

    property p_bit2_map;
        @(posedge sys_clk_i) disable iff (!rst_n_reg)
        s_l7_unexp_event |=> (l7_unexp == 8'($past(l7_unexp) + 8'h01));
    endproperty
    a_bit2_map: assert property (p_bit2_map) else $error("bit 2 error did not bump unexpected counter");

    property p_clear;
        @(posedge sys_clk_i) disable iff (!rst_n_reg)
        lane7_counter_clears_reg[0] |=> (l7_disp == 8'h00);
    endproperty
    a_clear: assert property (p_clear) else $error("lane7 clear did not zero counter");

    property p_hold;
        @(posedge sys_clk_i) disable iff (!rst_n_reg)
        (lane0_counter_saturate_enable_reg[2] && l0_unexp == 8'hff && !lane0_counter_clears_i[2])
            |=> (l0_unexp == 8'hff);
    endproperty
    a_hold: assert property (p_hold) else $error("held counter left terminal count");

    sequence s_l7_wrap_event;
        lane7_counter_enables_reg[1] && !lane7_counter_clears_reg[1] && lane7_errors_i[1] && (l7_inval == 8'hff);
    endsequence

    property p_wrap;
        @(posedge sys_clk_i) disable iff (!rst_n_reg)
        s_l7_wrap_event |=> (l7_inval == 8'h00);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");

    property p_disabled_stable;
        @(posedge sys_clk_i) disable iff (!rst_n_reg)
        (!lane6_counter_enables_reg[0] && !lane6_counter_clears_reg[0]) |=> $stable(l6_disp);
    endproperty
    a_disabled_stable: assert property (p_disabled_stable) else $error("disabled counter changed");

    property p_no_error_stable;
        @(posedge sys_clk_i) disable iff (!rst_n_reg)
        (!lane7_errors_i[0] && !lane7_counter_clears_reg[0]) |=> $stable(l7_disp);
    endproperty
    a_no_error_stable: assert property (p_no_error_stable) else $error("counter moved without error");
endmodule : lecc_top

// [verif/lecc_err_source.sv]
/*
 * Far-end error source: pulses the error strobes of lanes 0, 6 and 7.
 * Assumes the block samples strobes on the rising edge of clk_i.
 */
module lecc_err_source
(
    input wire logic clk_i,
    output logic [2:0] lane0_errors_o,
    output logic [2:0] lane6_errors_o,
    output logic [2:0] lane7_errors_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] err_reg = 9'h000;
    assign lane0_errors_o = err_reg[2:0];
    assign lane6_errors_o = err_reg[5:3];
    assign lane7_errors_o = err_reg[8:6];
    // Slot 0, 1, 2 is lane 0, 6, 7; back to back pulses stress one count per cycle
    task automatic burst(input int slot, input int bit_idx, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_i);
            err_reg <= 9'h001 << (slot * 3 + bit_idx);
        end
        @(posedge clk_i);
        err_reg <= 9'h000;
    endtask : burst
endmodule : lecc_err_source

// [verif/lecc_top_test.sv]
/*
 * Self-checking bench for the lane error counter control block.
 * Assumes the error source model and the design are on one clock.
 */
module lecc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [2:0] l0_en = 3'h7;
    logic [2:0] l0_clr = 3'h7;
    logic [2:0] l0_err, l6_err, l7_err;
    logic [23:0] l0_cnt, l6_cnt, l7_cnt;
    int num_errors = 0;
    int comparisons = 0;

    initial
    begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    lecc_top i_lecc_top (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .lane0_counter_enables_i(l0_en), .lane0_counter_clears_i(l0_clr), .lane0_errors_i(l0_err),
        .lane6_errors_i(l6_err), .lane7_errors_i(l7_err), .lane0_counts_o(l0_cnt),
        .lane6_counts_o(l6_cnt), .lane7_counts_o(l7_cnt));
    lecc_err_source i_lecc_err_source (.clk_i(sys_clk_i), .lane0_errors_o(l0_err),
        .lane6_errors_o(l6_err), .lane7_errors_o(l7_err));

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk({16'h0000, reg_rdata_o}, {16'h0000, exp});
    endtask : rd

    // Let the last strobe land in the counter before looking
    task automatic run(input int slot, input int bit_idx, input int n);
        i_lecc_err_source.burst(slot, bit_idx, n);
        @(posedge sys_clk_i);
        #1;
    endtask : run

    task results;
        if (num_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    initial
    begin
        #40000;
        num_errors++;
        results();
    end

    initial
    begin
        repeat (12) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rd(lecc_pkg::LANE6_CTRL_OFFSET, 8'h3f);
        rd(lecc_pkg::LANE7_CTRL_OFFSET, 8'h3f);
        rd(lecc_pkg::LANE0_SAT_OFFSET, 8'h07);
        rd(12'h489, 8'h00);
        run(2, 2, 2);
        chk(l7_cnt, 24'h000000);
        wr(lecc_pkg::LANE6_CTRL_OFFSET, 8'h38);
        wr(lecc_pkg::LANE7_CTRL_OFFSET, 8'h38);
        @(posedge sys_clk_i);
        l0_clr <= 3'h0;
        rd(lecc_pkg::LANE7_CTRL_OFFSET, 8'h38);
        run(2, 2, 3);
        chk(l7_cnt, 24'h030000);
        run(1, 0, 5);
        chk(l6_cnt, 24'h000005);
        run(1, 1, 1);
        chk(l6_cnt, 24'h000105);
        wr(lecc_pkg::LANE6_CTRL_OFFSET, 8'h30);
        run(1, 0, 2);
        chk(l6_cnt, 24'h000105);
        wr(lecc_pkg::LANE7_CTRL_OFFSET, 8'h3c);
        run(2, 2, 1);
        chk(l7_cnt, 24'h000000);
        wr(lecc_pkg::LANE7_CTRL_OFFSET, 8'h38);
        run(2, 1, 257);
        chk(l7_cnt, 24'h000100);
        run(0, 2, 260);
        chk(l0_cnt, 24'hff0000);
        // Hold field changed only with no lane traffic, as if the core sat in soft reset
        wr(lecc_pkg::LANE0_SAT_OFFSET, 8'h06);
        run(0, 0, 257);
        chk(l0_cnt, 24'hff0001);
        @(posedge sys_clk_i);
        l0_clr <= 3'h4;
        run(0, 2, 1);
        chk(l0_cnt, 24'h000001);
        @(posedge sys_clk_i);
        l0_en <= 3'h6;
        run(0, 0, 2);
        chk(l0_cnt, 24'h000001);
        results();
    end
endmodule : lecc_top_test
